// *** common/ntc_regs.svh ***
// Purpose: Register indexes, field positions, reset values and counts
// Assumes: Index times four is the APB byte address
// Notes:   Definitions only
//
// Overview of operation
// - Four-bit write-only mode register, cleared reset/stop
// - Mode write takes effect second cycle after
// - Top bit reload select, low bits prescale
// - Three-bit read/write output mode, cleared reset/stop
// - Output mode: port, toggle, low, high
// - Load nibbles write-only; low cleared, high undefined
// - Low nibble write leaves counter untouched
// - High nibble write loads full counter value
// - Low nibble kept across loads for reuse
// - High read returns live bits, snapshots low
// - Read and write registers share two addresses
// - Counter increments once per prescaler tick
// - Tick at 255 overflows; reload or wrap
// - Each overflow sets the interrupt request flag
// - Toggle mode inverts pin on overflow tick
`ifndef NTC_REGS_SVH
`define NTC_REGS_SVH
// Register indexes
`define NTC_IDX_MODE    6'h0D
`define NTC_IDX_LOW     6'h0E
`define NTC_IDX_HIGH    6'h0F
`define NTC_IDX_OUTMODE 6'h14
// Field positions in the mode register
`define NTC_RELOAD_BIT  3
`define NTC_PRESC_MSB   2
// Reset values
`define NTC_MODE_RST    4'h0
`define NTC_OUTMODE_RST 3'h0
`define NTC_LOW_RST     4'h0
// Prescaler width covers the 2048-cycle period
`define NTC_PRE_W       11
`define NTC_COUNT_MAX   8'hFF
`endif

// *** common/ntc_pkg.sv ***
// Purpose: Types shared by the timer block
// Assumes: Nothing beyond the register header
// Notes:   Holds the output mode and register select types
package ntc_pkg;
	// Output pin function codes
	typedef enum logic [2:0] {
		OUT_PORT   = 3'h0,
		OUT_TOGGLE = 3'h1,
		OUT_LOW    = 3'h2,
		OUT_HIGH   = 3'h3
	} ntc_outmode_e;
	// Decoded register target
	typedef enum {
		SEL_NONE,
		SEL_MODE,
		SEL_LOW,
		SEL_HIGH,
		SEL_OUTMODE
	} ntc_sel_e;
endpackage

// *** hdl/ntc_timer.sv ***
// Purpose: Eight-bit up counter with prescaler, reload and pin output
// Assumes: APB slave, zero wait states, one 10 MHz clock
// Notes:   The interrupt flag itself lives in the interrupt controller
`include "ntc_regs.svh"

module ntc_timer (
	input  wire logic        clock,           // System clock
	input  wire logic        nrst,            // Synchronous reset, low
	input  wire logic        stopMode,        // Stop mode level
	input  wire logic        psel,            // APB select
	input  wire logic        penable,         // APB access phase
	input  wire logic        pwrite,          // APB direction
	input  wire logic [7:0]  paddr,           // APB byte address
	input  wire logic [31:0] pwdata,          // APB write data
	output logic      [31:0] prdata,          // APB read data
	output logic             pready,          // APB ready
	output logic             pslverr,         // APB error
	input  wire logic        sharedPortBit,   // Port value for the pin
	output logic             timerOutputPin,  // Pin level
	output logic             pinIsTimer,      // Pin owned by the timer
	output logic             overflowIrqSet   // Sets overflow_irq_flag
);

	// Complete register state of the block
	typedef struct packed {
		logic [3:0]              mode;      // Applied mode
		logic [3:0]              modePend;  // Mode awaiting effect
		logic                    pendValid; // Pending mode waiting
		logic [2:0]              outMode;   // Output pin mode
		logic [3:0]              loadLow;   // Low load nibble
		logic [3:0]              loadHigh;  // High load nibble
		logic [7:0]              count;     // Counter
		logic [3:0]              snap;      // Low read snapshot
		logic [`NTC_PRE_W-1:0]   pre;       // Prescaler
		logic                    pin;       // Timer pin level
		logic                    ovf;       // Overflow pulse
		logic [31:0]             rdata;     // Read data
		logic                    err;       // Error answer
	} ntc_state_s;

	ntc_state_s st;       // Current state
	ntc_state_s next_st;  // Next state

	// Register target from the byte address
	function automatic ntc_pkg::ntc_sel_e regSel(input logic [7:0] a);
		logic [5:0] idx;
		idx = a[7:2];
		if (a[1:0] != 2'h0) begin
			regSel = ntc_pkg::SEL_NONE;
		end else if (idx == `NTC_IDX_MODE) begin
			regSel = ntc_pkg::SEL_MODE;
		end else if (idx == `NTC_IDX_LOW) begin
			regSel = ntc_pkg::SEL_LOW;
		end else if (idx == `NTC_IDX_HIGH) begin
			regSel = ntc_pkg::SEL_HIGH;
		end else if (idx == `NTC_IDX_OUTMODE) begin
			regSel = ntc_pkg::SEL_OUTMODE;
		end else begin
			regSel = ntc_pkg::SEL_NONE;
		end
	endfunction

	// Prescaler bits that must all be one for a tick
	function automatic logic [`NTC_PRE_W-1:0] divMask(input logic [2:0] s);
		unique case (s)
			3'h0: divMask = 11'h7FF; // 2048 cycles
			3'h1: divMask = 11'h3FF; // 1024 cycles
			3'h2: divMask = 11'h1FF; // 512 cycles
			3'h3: divMask = 11'h07F; // 128 cycles
			3'h4: divMask = 11'h01F; // 32 cycles
			3'h5: divMask = 11'h007; // 8 cycles
			3'h6: divMask = 11'h003; // 4 cycles
			3'h7: divMask = 11'h001; // 2 cycles
		endcase
	endfunction

	ntc_pkg::ntc_sel_e sel;          // Decoded target
	logic              setupPhase;   // APB setup cycle
	logic              wrDone;       // Write completes
	logic              tick;         // Counter tick enable
	logic              overflow;     // Tick at full count
	logic              loadNow;      // High nibble write

	// Bus phase decode
	always_comb begin
		sel        = regSel(paddr);
		setupPhase = psel && !penable;
		wrDone     = psel && penable && pwrite;
		loadNow    = wrDone && (sel == ntc_pkg::SEL_HIGH);
	end

	// One tick per selected period from the free-running prescaler
	always_comb begin
		tick = (st.pre & divMask(st.mode[`NTC_PRESC_MSB:0])) ==
			divMask(st.mode[`NTC_PRESC_MSB:0]);
		overflow = tick && (st.count == `NTC_COUNT_MAX);
	end

	// Next state of everything
	always_comb begin
		next_st     = st;
		next_st.ovf = 1'b0;
		// Prescaler never stops, so mode changes keep their phase
		next_st.pre = st.pre + 11'h001;

		// A staged mode write is applied one cycle late
		if (st.pendValid) begin
			next_st.mode      = st.modePend;
			next_st.pendValid = 1'b0;
		end

		// Counter ticks; a load in the same cycle wins below
		if (tick) begin
			next_st.count = st.count + 8'h01;
		end
		if (overflow) begin
			next_st.ovf = 1'b1;
			if (st.mode[`NTC_RELOAD_BIT]) begin
				next_st.count = {st.loadHigh, st.loadLow};
			end else begin
				next_st.count = 8'h00;
			end
			// Pin update on the overflow tick
			unique case (st.outMode)
				ntc_pkg::OUT_TOGGLE: next_st.pin = !st.pin;
				ntc_pkg::OUT_LOW:    next_st.pin = 1'b0;
				ntc_pkg::OUT_HIGH:   next_st.pin = 1'b1;
				default:             next_st.pin = st.pin;
			endcase
		end

		// Register writes at the access phase
		if (wrDone) begin
			unique case (sel)
				ntc_pkg::SEL_MODE: begin
					next_st.modePend  = pwdata[3:0];
					next_st.pendValid = 1'b1;
				end
				ntc_pkg::SEL_LOW: begin
					// Stored only; the counter keeps running
					next_st.loadLow = pwdata[3:0];
				end
				ntc_pkg::SEL_HIGH: begin
					next_st.loadHigh = pwdata[3:0];
					// Reuses the stored low nibble
					next_st.count = {pwdata[3:0], st.loadLow};
				end
				ntc_pkg::SEL_OUTMODE: begin
					next_st.outMode = pwdata[2:0];
				end
				default: begin
					next_st.outMode = st.outMode; // Unmapped write
				end
			endcase
		end

		// Read data and error are prepared in the setup cycle
		if (setupPhase) begin
			next_st.rdata = 32'h0000_0000;
			next_st.err   = 1'b0;
			if (!pwrite) begin
				unique case (sel)
					ntc_pkg::SEL_HIGH: begin
						// Live high bits, low bits frozen together
						next_st.rdata[3:0] = st.count[7:4];
						next_st.snap       = st.count[3:0];
					end
					ntc_pkg::SEL_LOW: begin
						next_st.rdata[3:0] = st.snap;
					end
					ntc_pkg::SEL_OUTMODE: begin
						next_st.rdata[2:0] = st.outMode;
					end
					ntc_pkg::SEL_MODE: begin
						// Write-only register reads as zero
						next_st.rdata = 32'h0000_0000;
					end
					default: begin
						next_st.err = 1'b1; // Unmapped
					end
				endcase
			end else begin
				next_st.err = (sel == ntc_pkg::SEL_NONE);
			end
		end

		// Stop mode clears the mode registers and low nibble
		if (stopMode) begin
			next_st.mode      = `NTC_MODE_RST;
			next_st.pendValid = 1'b0;
			next_st.outMode   = `NTC_OUTMODE_RST;
			next_st.loadLow   = `NTC_LOW_RST;
		end
	end

	// Single state register; the high load nibble is not reset
	always_ff @(posedge clock) begin
		if (!nrst) begin
			st.mode      <= `NTC_MODE_RST;
			st.modePend  <= `NTC_MODE_RST;
			st.pendValid <= 1'b0;
			st.outMode   <= `NTC_OUTMODE_RST;
			st.loadLow   <= `NTC_LOW_RST;
			st.count     <= 8'h00;
			st.snap      <= 4'h0;
			st.pre       <= 11'h000;
			st.pin       <= 1'b0;
			st.ovf       <= 1'b0;
			st.rdata     <= 32'h0000_0000;
			st.err       <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	always_comb begin
		pready         = 1'b1; // Zero wait states
		prdata         = st.rdata;
		pslverr        = st.err && psel && penable;
		overflowIrqSet = st.ovf;
		// Codes 1xx and 000 leave the pin to the port
		pinIsTimer     = (st.outMode != ntc_pkg::OUT_PORT) &&
			!st.outMode[2];
		timerOutputPin = pinIsTimer ? st.pin : sharedPortBit;
	end

	// Checks run on the same clock and reset
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	mode_delay_a: assert property (
		wrDone && sel == ntc_pkg::SEL_MODE && !stopMode
		##1 !stopMode |=> st.mode == $past(pwdata[3:0], 2))
		else $error("Mode write not applied two cycles later");

	mode_stop_a: assert property (
		stopMode |=> st.mode == 4'h0 && st.outMode == 3'h0)
		else $error("Stop mode did not clear mode registers");

	low_keep_a: assert property (
		wrDone && sel == ntc_pkg::SEL_LOW && !tick
		|=> st.count == $past(st.count))
		else $error("Low nibble write changed the counter");

	high_load_a: assert property (
		wrDone && sel == ntc_pkg::SEL_HIGH
		|=> st.count == {$past(pwdata[3:0]), $past(st.loadLow)})
		else $error("High nibble write did not load counter");

	snap_read_a: assert property (
		setupPhase && !pwrite && sel == ntc_pkg::SEL_HIGH
		|=> st.snap == $past(st.count[3:0])
		&& prdata[3:0] == $past(st.count[7:4]))
		else $error("High read did not capture snapshot");

	count_step_a: assert property (
		tick && !overflow && !wrDone
		|=> st.count == $past(st.count) + 8'h01)
		else $error("Counter did not step on tick");

	ovf_wrap_a: assert property (
		overflow && !wrDone && !st.mode[`NTC_RELOAD_BIT]
		|=> st.count == 8'h00 ##0 overflowIrqSet)
		else $error("Free-running overflow did not wrap");

	ovf_reload_a: assert property (
		overflow && !wrDone && st.mode[`NTC_RELOAD_BIT]
		|=> st.count == $past({st.loadHigh, st.loadLow}))
		else $error("Reload overflow loaded wrong value");

	irq_pulse_a: assert property (
		overflowIrqSet |-> $past(overflow) ##1 !overflowIrqSet)
		else $error("Overflow pulse without cause or too long");

	pin_toggle_a: assert property (
		overflow && st.outMode == 3'h1 && !wrDone && !stopMode
		|=> timerOutputPin != $past(st.pin))
		else $error("Toggle mode did not invert pin");

	pin_port_a: assert property (
		st.outMode[2] || st.outMode == 3'h0 |-> timerOutputPin == sharedPortBit)
		else $error("Port setting not passed to pin");

	tick_rate_a: assert property (
		st.mode[2:0] == 3'h7 && !st.pendValid && !wrDone && !stopMode && tick
		##1 !stopMode |-> !tick ##1 tick)
		else $error("Fastest prescale not every two cycles");

	// Load nibble storage; stop mode acts like reset here
	stop_low_a: assert property (
		stopMode |=> st.loadLow == 4'h0)
		else $error("Stop mode did not clear low load nibble");

	low_store_a: assert property (
		wrDone && sel == ntc_pkg::SEL_LOW && !stopMode
		|=> st.loadLow == $past(pwdata[3:0]))
		else $error("Low load nibble not stored");

	low_hold_a: assert property (
		wrDone && sel == ntc_pkg::SEL_HIGH && !stopMode
		|=> st.loadLow == $past(st.loadLow))
		else $error("High write disturbed the low load nibble");

	// Read answers, latched in the setup cycle
	low_read_a: assert property (
		setupPhase && !pwrite && sel == ntc_pkg::SEL_LOW
		|=> prdata[3:0] == $past(st.snap))
		else $error("Low read did not return snapshot");

	mode_read_a: assert property (
		setupPhase && !pwrite && sel == ntc_pkg::SEL_MODE
		|=> prdata == 32'h0000_0000)
		else $error("Write-only mode register read not zero");

	om_read_a: assert property (
		setupPhase && !pwrite && sel == ntc_pkg::SEL_OUTMODE
		|=> prdata == {29'h0, $past(st.outMode)})
		else $error("Output mode read back wrong");

	pin_low_a: assert property (
		overflow && st.outMode == 3'h2 && !wrDone && !stopMode
		|=> timerOutputPin == 1'b0)
		else $error("Low output mode did not drive pin low");

	pin_high_a: assert property (
		overflow && st.outMode == 3'h3 && !wrDone && !stopMode
		|=> timerOutputPin == 1'b1)
		else $error("High output mode did not drive pin high");

	pin_hold_a: assert property (
		!overflow |=> st.pin == $past(st.pin))
		else $error("Timer pin level moved without overflow");

	// Scenarios the bench is expected to reach
	cover_reload_c: cover property (
		overflow && st.mode[`NTC_RELOAD_BIT]);
	cover_toggle_c: cover property (
		overflow && st.outMode == 3'h1);
	cover_read_pair_c: cover property (
		setupPhase && !pwrite && sel == ntc_pkg::SEL_HIGH
		##[2:20] setupPhase && !pwrite && sel == ntc_pkg::SEL_LOW);
	cover_wrap_c: cover property (
		overflow && !st.mode[`NTC_RELOAD_BIT]);
	cover_stop_c: cover property (
		stopMode && st.outMode != 3'h0);

endmodule

// *** test/tb.sv ***
// Purpose: Self-checking bench for the nibble timer over APB
// Assumes: Zero wait states, overflow pulse one cycle after the tick
// Notes:   Reload of 0xFF makes every tick overflow, so pulse gap = period
`include "ntc_regs.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [3:0] mode;  // Reload bit and prescale code
		logic [2:0] om;    // Output pin mode
		logic [11:0] gap;  // Cycles between overflow pulses
	} ntc_row_s;
	localparam logic [7:0] A_MODE = {`NTC_IDX_MODE, 2'b00};     // Mode register
	localparam logic [7:0] A_LOW  = {`NTC_IDX_LOW, 2'b00};      // Low nibbles
	localparam logic [7:0] A_HIGH = {`NTC_IDX_HIGH, 2'b00};     // High nibbles
	localparam logic [7:0] A_OM   = {`NTC_IDX_OUTMODE, 2'b00};  // Output mode
	logic        clock = 1'b0;       // Bench clock
	logic        nrst = 1'b0;        // Reset, low
	logic        stopMode = 1'b0;    // Stop mode level
	logic        psel = 1'b0;        // APB select
	logic        penable = 1'b0;     // APB access
	logic        pwrite = 1'b0;      // APB direction
	logic [7:0]  paddr = 8'h00;      // APB address
	logic [31:0] pwdata = 32'h0;     // APB write data
	logic [31:0] prdata;             // APB read data
	logic        pready;             // APB ready
	logic        pslverr;            // APB error
	logic        sharedPortBit = 1'b1;  // High, so port mode differs from reset pin
	logic        timerOutputPin;     // Pin level
	logic        pinIsTimer;         // Pin ownership
	logic        overflowIrqSet;     // Overflow pulse
	int          n_fail = 0;         // Mismatches
	int          n_checks = 0;       // Comparisons
	logic [31:0] rd;                 // Last read data
	logic        er;                 // Last error flag
	logic        p1;                 // Pin level at a reference pulse
	int          n;                  // Measured gap
	// Rows cover every prescale code and every pin mode
	// The last row leaves a slow reload of 0xFF for the nibble tests
	ntc_row_s rows [9] = '{'{4'hF, 3'h1, 12'h002}, '{4'hE, 3'h2, 12'h004},
		'{4'hD, 3'h3, 12'h008}, '{4'hC, 3'h5, 12'h020}, '{4'hB, 3'h0, 12'h080},
		'{4'hA, 3'h1, 12'h200}, '{4'h9, 3'h3, 12'h400}, '{4'h7, 3'h1, 12'h200},
		'{4'h8, 3'h6, 12'h800}};

	ntc_timer DUT (.clock(clock), .nrst(nrst), .stopMode(stopMode), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sharedPortBit(sharedPortBit), .timerOutputPin(timerOutputPin),
		.pinIsTimer(pinIsTimer), .overflowIrqSet(overflowIrqSet));

	// 100 ns period
	always #50 clock = ~clock;

	// Value comparison, counted
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Cycles until the next overflow pulse, bounded
	task automatic waitPulse(output int c);
		c = 0;
		do begin
			@(negedge clock);
			c++;
		end while (overflowIrqSet !== 1'b1 && c < 5000);
	endtask

	// Verdict, reached from the main sequence or the watchdog
	task automatic conclude;
		$display("Checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Hang guard, well beyond the expected run
	initial begin
		repeat (40000) @(posedge clock);
		n_fail++;
		conclude();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		apb(1'b0, A_OM, 32'h0);
		chk("outmode reset", 32'h0, rd);
		apb(1'b0, A_MODE, 32'h0);
		chk("mode read", 32'h0, rd);
		chk("port pin", 32'(sharedPortBit), 32'(timerOutputPin));
		chk("pin owner", 32'h0, 32'(pinIsTimer));
		apb(1'b0, 8'h00, 32'h0);
		chk("unmapped err", 32'h1, 32'(er));
		$display("Test reset done");
		foreach (rows[i]) begin
			apb(1'b1, A_OM, 32'(rows[i].om));
			apb(1'b1, A_MODE, 32'(rows[i].mode));
			repeat (3) @(posedge clock);
			apb(1'b1, A_LOW, 32'hF);
			apb(1'b1, A_HIGH, 32'hF);
			waitPulse(n);
			waitPulse(n);
			p1 = timerOutputPin;
			waitPulse(n);
			chk("gap", 32'(rows[i].gap), 32'(n));
			chk("owner", 32'(rows[i].om inside {3'h1, 3'h2, 3'h3}), 32'(pinIsTimer));
			case (rows[i].om)
				3'h1: chk("toggle", 32'(!p1), 32'(timerOutputPin));
				3'h2: chk("low", 32'h0, 32'(timerOutputPin));
				3'h3: chk("high", 32'h1, 32'(timerOutputPin));
				default: chk("port", 32'(sharedPortBit), 32'(timerOutputPin));
			endcase
			$display("Test row %0d done", i);
		end
		// Just after an overflow the next tick is 2047 cycles away
		waitPulse(n);
		apb(1'b1, A_LOW, 32'hA);
		apb(1'b0, A_HIGH, 32'h0);
		chk("high after low", 32'hF, rd);
		apb(1'b1, A_HIGH, 32'h5);
		apb(1'b0, A_HIGH, 32'h0);
		chk("high read", 32'h5, rd);
		apb(1'b0, A_LOW, 32'h0);
		chk("low snapshot", 32'hA, rd);
		apb(1'b1, A_HIGH, 32'h3);
		apb(1'b0, A_HIGH, 32'h0);
		apb(1'b0, A_LOW, 32'h0);
		chk("kept low", 32'hA, rd);
		apb(1'b0, A_OM, 32'h0);
		chk("outmode rw", 32'h6, rd);
		$display("Test nibbles done");
		@(posedge clock);
		stopMode <= 1'b1;
		repeat (2) @(posedge clock);
		stopMode <= 1'b0;
		apb(1'b0, A_OM, 32'h0);
		chk("outmode stop", 32'h0, rd);
		apb(1'b1, A_HIGH, 32'h7);
		apb(1'b0, A_HIGH, 32'h0);
		chk("high after stop", 32'h7, rd);
		apb(1'b0, A_LOW, 32'h0);
		chk("low cleared", 32'h0, rd);
		$display("Test stop done");
		// Reset in mid-run must clear the stored low nibble again
		apb(1'b1, A_LOW, 32'h9);
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		apb(1'b1, A_HIGH, 32'h2);
		apb(1'b0, A_HIGH, 32'h0);
		chk("high after reset", 32'h2, rd);
		apb(1'b0, A_LOW, 32'h0);
		chk("low after reset", 32'h0, rd);
		$display("Test second reset done");
		conclude();
	end
endmodule
